/* rtl/aio_pkg.sv */
package aio_pkg;

   // ------------------------------------------------------------
   // clock and register map
   // ------------------------------------------------------------
   localparam int unsigned CORE_HZ = 50_000_000;
   localparam logic [6:0] OFS_INPUT_RATE_STATUS = 7'h01;
   localparam logic [6:0] OFS_TX_MODE           = 7'h5A;
   localparam logic [6:0] OFS_INPUT_FMT         = 7'h54;
   localparam logic [6:0] OFS_RX_MODE           = 7'h4A;
   localparam logic [6:0] OFS_SERIAL_FMT        = 7'h44;
   localparam logic [6:0] OFS_LINK_MODE         = 7'h36;
   localparam logic [6:0] OFS_AUX_CONTROL       = 7'h5C;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int MODE_PORT_SEL  = 2;   // 0 serial port, 1 s/pdif
   localparam int TXM_REQ_POL    = 4;   // 0 request active low
   localparam int FMT_MASTER     = 7;
   localparam int FMT_WS_POL     = 3;
   localparam int FMT_NO_DELAY   = 1;
   localparam int FMT_RIGHT_JUST = 0;
   localparam int RATE_AUTO      = 0;
   localparam int RATE_SCALE_LO  = 5;
   localparam int LINK_RECONF    = 4;
   localparam int AUX_COMPRESS   = 0;
   localparam int AUX_EXT_RESET  = 1;
   localparam logic [7:0] RATE_RW_MASK = 8'h79;
   localparam logic [7:0] RATE_HW_MASK = 8'h78;

   // ------------------------------------------------------------
   // field codes
   // ------------------------------------------------------------
   localparam logic [1:0] LEN_24        = 2'b10;
   localparam logic [1:0] MCLK_OFF      = 2'b00;
   localparam logic [1:0] MCLK_48K      = 2'b01;
   localparam logic [1:0] MCLK_44K1     = 2'b10;
   localparam logic [1:0] SCALE_HALF    = 2'b01;
   localparam logic [1:0] SCALE_UNITY   = 2'b10;
   localparam logic [3:0] DET_MISS      = 4'hB;  // unity, no input
   localparam logic [15:0] PER_MAX      = 16'hFFFF;

   // mclk phase increments: twice 256 fs over core rate, 24-bit acc
   localparam logic [23:0] NCO_48K  = 24'((64'd512 * 64'd48000 << 24)
                                          / CORE_HZ);
   localparam logic [23:0] NCO_44K1 = 24'((64'd512 * 64'd44100 << 24)
                                          / CORE_HZ);
   localparam logic [23:0] NCO_32K  = 24'((64'd512 * 64'd32000 << 24)
                                          / CORE_HZ);

   // detectable rates and their {scale, fundamental} codes
   localparam int DET_N         = 8;
   localparam int DET_TOL_SHIFT = 5;
   localparam int unsigned DET_HZ [DET_N] =
      '{48000, 44100, 32000, 24000, 22050, 12000, 11025, 8000};
   localparam logic [3:0] DET_CODE [DET_N] =
      '{4'h8, 4'h9, 4'hA, 4'h4, 4'h5, 4'h0, 4'h1, 4'h2};

   // s/pdif subframe layout, counted after the preamble
   localparam logic [3:0] SPD_PRE_UI   = 4'h8;
   localparam logic [4:0] SPD_LAST_BIT = 5'd27;
   localparam int         SPD_C_POS    = 26;
   localparam logic [5:0] SPD_CS_BITS  = 6'd32;

   // ------------------------------------------------------------
   // carriers and state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {PRE_B, PRE_M, PRE_W} aio_pre_t;

   typedef struct packed {
      logic o;
      logic oe;
   } aio_pin_t;

   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } aio_bus_t;

   typedef struct packed {
      logic [23:0] data;
      logic        right;
      logic        valid;
   } aio_sample_t;

   typedef struct packed {
      logic        cfg_done;
      logic        role_rx;
      logic [7:0]  tx_mode, rx_mode, in_fmt, out_fmt, rate_stat, aux;
      logic [7:0]  a_tx_mode, a_rx_mode, a_in_fmt, a_out_fmt, a_rate;
      logic [7:0]  a_aux;
      logic [7:0]  rdata;
      logic        clk_s1, clk_s2, ws_s1, ws_s2, dat_s1, dat_s2;
      logic        spd_s1, spd_s2, role_s1, role_s2;
      logic        bclk_prev, ws_last, ws_det_prev, spd_prev;
      logic [31:0] sh;
      logic [5:0]  bitcnt;
      aio_sample_t aud;
      logic [7:0]  pk_cnt;
      logic [22:0] pk_max;
      logic [3:0]  drop;
      logic        pkt_end;
      logic [15:0] per_cnt;
      logic [23:0] acc;
      logic        mclk;
      logic [9:0]  mcnt;
      logic [31:0] osh;
      logic        rx_take, rx_right;
      logic [7:0]  spd_cnt;
      logic [3:0]  pre_ui;
      aio_pre_t    pre_kind;
      logic        pre_first, half;
      logic [4:0]  bit_idx;
      logic [27:0] spd_word;
      logic [31:0] cs, cs_out;
      logic [5:0]  cs_idx;
      logic        cs_valid;
      aio_pin_t    clk_p, ws_p, dat_p, req_p, spd_p, mclk_p;
      aio_pin_t    cs_p, sck_p, mosi_p;
   } aio_state_t;

endpackage

/* rtl/aio_top.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module aio_top
  import aio_pkg::*;
#(
   parameter int unsigned PACKET_SAMPLES = 32,
   parameter int unsigned UI_CYCLES      = 8
) (
   input  wire logic             CORE_CLK,                 // 50 MHz
   input  wire logic             RESET_N,                  // sync reset
   input  wire aio_pkg::aio_bus_t BUS,                     // register port
   output logic [7:0]            REG_RDATA,                // read data
   input  wire logic             CFG_DONE,                 // loader done
   input  wire logic             ROLE_RX_I,                // role strap
   input  wire logic             LDR_CS_N,                 // loader select
   input  wire logic             LDR_SCK,                  // loader clock
   input  wire logic             LDR_MOSI,                 // loader data
   input  wire logic             AUD_READY,                // sink ready
   input  wire logic [23:0]      RX_SAMPLE,                // sample to play
   input  wire logic             CLK_I,                    // bit clock in
   input  wire logic             WS_I,                     // word sync in
   input  wire logic             DATA_I,                   // data in
   input  wire logic             SPDIF_IO_PIN_I,           // s/pdif in
   output aio_pkg::aio_pin_t     CLK_P,                    // bit clock pin
   output aio_pkg::aio_pin_t     WS_P,                     // word sync pin
   output aio_pkg::aio_pin_t     DATA_P,                   // data pin
   output aio_pkg::aio_pin_t     REQ_P,                    // request pin
   output aio_pkg::aio_pin_t     SPDIF_IO_PIN_P,           // s/pdif pin
   output aio_pkg::aio_pin_t     MCLK_P,                   // master clock
   output aio_pkg::aio_pin_t     SPI_MASTER_CHIP_SELECT_N, // spi select
   output aio_pkg::aio_pin_t     SPI_MASTER_SERIAL_CLOCK,  // spi clock
   output aio_pkg::aio_pin_t     SPI_MASTER_DATA_OUT,      // spi data
   output aio_pkg::aio_sample_t  AUD_OUT,                  // captured audio
   output logic                  PKT_END,                  // packet done
   output logic [3:0]            PKT_DROP,                 // lsbs to drop
   output logic [31:0]           CSTAT,                    // channel status
   output logic                  CSTAT_VALID,              // status pulse
   output logic                  RX_TAKE,                  // sample taken
   output logic                  RX_RIGHT                  // channel taken
);
   import aio_pkg::*;

   // ------------------------------------------------------------
   // constants and locals
   // ------------------------------------------------------------
   localparam logic [7:0] UI_SHORT = 8'((3 * UI_CYCLES) / 2);
   localparam logic [7:0] UI_LONG  = 8'((5 * UI_CYCLES) / 2);
   localparam logic [7:0] PK_LAST  = 8'(PACKET_SAMPLES - 1);

   aio_state_t  q, d;
   logic [24:0] nco_sum;
   logic [23:0] nco_inc;
   logic [3:0]  sc;
   logic        bclk_int, ws_int, master, bclk_in, ws_in, rise, fall;
   logic        serial_tx, spdif_tx, serial_rx, spdif_rx;
   logic        len24_in, len24_out, delay_in, emit, emit_r;
   logic [31:0] sh_n, word;
   logic [23:0] emit_s, o_s;
   logic [5:0]  last_pos, cs_i;
   logic [1:0]  ui;
   logic        spd_edge, spd_got, spd_bit;
   logic [3:0]  det_code;
   logic [7:0]  wmask;
   logic [15:0] nom;

   // width needed by a magnitude beyond 16 bits
   function automatic logic [3:0] drop_bits(input logic [22:0] m);
      logic [4:0] w;
      w = 5'd1;
      for (int i = 0; i < 23; i++) begin
         if (m[i]) begin
            w = 5'(i + 2);
         end
      end
      return (w > 5'd16) ? 4'(w - 5'd16) : 4'h0;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      d.rdata = 8'h00;
      d.aud.valid = 1'b0;
      d.pkt_end = 1'b0;
      d.cs_valid = 1'b0;
      d.rx_take = 1'b0;
      emit = 1'b0;
      emit_s = 24'h000000;
      emit_r = 1'b0;
      spd_got = 1'b0;
      spd_bit = 1'b0;
      ui = 2'd3;
      cs_i = 6'd0;
      word = 32'h00000000;
      o_s = 24'h000000;
      wmask = 8'h00;
      nom = 16'h0000;

      // audio, s/pdif and role pin inputs cross over two flops before use
      d.clk_s1 = CLK_I;
      d.clk_s2 = q.clk_s1;
      d.ws_s1 = WS_I;
      d.ws_s2 = q.ws_s1;
      d.dat_s1 = DATA_I;
      d.dat_s2 = q.dat_s1;
      d.spd_s1 = SPDIF_IO_PIN_I;
      d.spd_s2 = q.spd_s1;
      d.role_s1 = ROLE_RX_I;
      d.role_s2 = q.role_s1;

      // one port only per role, picked by mode bit 2
      serial_tx = !q.role_rx && !q.a_tx_mode[MODE_PORT_SEL];
      spdif_tx  = !q.role_rx && q.a_tx_mode[MODE_PORT_SEL];
      serial_rx = q.role_rx && !q.a_rx_mode[MODE_PORT_SEL];
      spdif_rx  = q.role_rx && q.a_rx_mode[MODE_PORT_SEL];

      // register writes
      if (BUS.wr) begin
         unique case (BUS.addr)
            OFS_TX_MODE:    d.tx_mode = BUS.wdata;
            OFS_RX_MODE:    d.rx_mode = BUS.wdata;
            OFS_INPUT_FMT:  d.in_fmt = BUS.wdata;
            OFS_SERIAL_FMT: d.out_fmt = BUS.wdata;
            OFS_AUX_CONTROL: d.aux = BUS.wdata;
            OFS_INPUT_RATE_STATUS: begin
               // rate fields are the user's only in manual mode
               wmask = BUS.wdata[RATE_AUTO] ? 8'h01 : RATE_RW_MASK;
               d.rate_stat = (q.rate_stat & ~wmask)
                           | (BUS.wdata & wmask);
            end
            default: ;
         endcase
      end

      // new settings, except the auto detect bit, only take hold on reconfigure or load end
      if ((BUS.wr && BUS.addr == OFS_LINK_MODE
           && BUS.wdata[LINK_RECONF]) || CFG_DONE) begin
         d.a_tx_mode = q.tx_mode;
         d.a_rx_mode = q.rx_mode;
         d.a_in_fmt = q.in_fmt;
         d.a_out_fmt = q.out_fmt;
         d.a_rate = q.rate_stat;
         d.a_aux = q.aux;
      end
      if (CFG_DONE) begin
         d.cfg_done = 1'b1;
         d.role_rx = q.role_s2;
      end

      // register reads, answered one cycle later
      if (BUS.rd) begin
         unique case (BUS.addr)
            OFS_TX_MODE:     d.rdata = q.tx_mode;
            OFS_RX_MODE:     d.rdata = q.rx_mode;
            OFS_INPUT_FMT:   d.rdata = q.in_fmt;
            OFS_SERIAL_FMT:  d.rdata = q.out_fmt;
            OFS_AUX_CONTROL: d.rdata = q.aux;
            OFS_INPUT_RATE_STATUS:
               d.rdata = q.rate_stat & RATE_RW_MASK;
            default: d.rdata = 8'h00;
         endcase
      end

      // mclk from a phase accumulator at 256 fs
      unique case (q.a_tx_mode[1:0])
         MCLK_48K:  nco_inc = NCO_48K;
         MCLK_44K1: nco_inc = NCO_44K1;
         default:   nco_inc = NCO_32K;
      endcase
      nco_sum = {1'b0, q.acc} + {1'b0, nco_inc};
      d.acc = nco_sum[23:0];
      if (nco_sum[24]) begin
         d.mclk = !q.mclk;
         if (!q.mclk) begin
            d.mcnt = q.mcnt + 10'd1;
         end
      end

      // master bit clock 64 fs scaled by the active scale factor
      if (q.a_rate[6:5] == SCALE_UNITY) begin
         sc = 4'd0;
      end else if (q.a_rate[6:5] == SCALE_HALF) begin
         sc = 4'd1;
      end else begin
         sc = 4'd2;
      end
      bclk_int = q.mcnt[4'd1 + sc];
      ws_int = q.mcnt[4'd7 + sc];
      master = q.role_rx || q.a_in_fmt[FMT_MASTER];
      bclk_in = master ? bclk_int : q.clk_s2;
      ws_in = master ? ws_int : q.ws_s2;
      d.bclk_prev = bclk_in;
      rise = bclk_in && !q.bclk_prev;
      fall = !bclk_in && q.bclk_prev;

      // serial capture: delay from bit 1, justification from bit 0
      len24_in = q.a_in_fmt[5:4] == LEN_24;
      delay_in = !q.a_in_fmt[FMT_NO_DELAY];
      last_pos = (len24_in ? 6'd23 : 6'd15) + {5'd0, delay_in};
      sh_n = {q.sh[30:0], q.dat_s2};
      if (serial_tx && rise) begin
         d.sh = sh_n;
         if (ws_in != q.ws_last) begin
            d.ws_last = ws_in;
            d.bitcnt = 6'd0;
            if (q.a_in_fmt[FMT_RIGHT_JUST]) begin
               emit = 1'b1;
               emit_s = len24_in ? q.sh[23:0] : {q.sh[15:0], 8'h00};
               emit_r = q.ws_last != q.a_in_fmt[FMT_WS_POL];
            end
         end else begin
            d.bitcnt = (q.bitcnt == 6'h3F) ? q.bitcnt : q.bitcnt + 6'd1;
            if (!q.a_in_fmt[FMT_RIGHT_JUST] && d.bitcnt == last_pos) begin
               emit = 1'b1;
               emit_s = len24_in ? sh_n[23:0] : {sh_n[15:0], 8'h00};
               emit_r = q.ws_last != q.a_in_fmt[FMT_WS_POL];
            end
         end
      end

      // rate detection on word sync period, slave input only
      det_code = DET_MISS;
      for (int i = 0; i < DET_N; i++) begin
         nom = 16'(CORE_HZ / DET_HZ[i]);
         if (q.per_cnt >= nom - (nom >> DET_TOL_SHIFT)
             && q.per_cnt <= nom + (nom >> DET_TOL_SHIFT)) begin
            det_code = DET_CODE[i];
         end
      end
      d.ws_det_prev = q.ws_s2;
      if (serial_tx && !q.a_in_fmt[FMT_MASTER]
          && d.rate_stat[RATE_AUTO]) begin
         d.per_cnt = (q.per_cnt == PER_MAX) ? PER_MAX : q.per_cnt + 16'd1;
         if (q.ws_s2 && !q.ws_det_prev) begin
            d.per_cnt = 16'd1;
            d.rate_stat = (d.rate_stat & ~RATE_HW_MASK)
                        | {1'b0, det_code, 3'b000};
         end else if (q.per_cnt == PER_MAX) begin
            d.rate_stat = (d.rate_stat & ~RATE_HW_MASK)
                        | {1'b0, DET_MISS, 3'b000};
         end
      end else begin
         d.per_cnt = 16'd0;
      end

      // s/pdif: interval between edges measured in unit intervals
      d.spd_prev = q.spd_s2;
      spd_edge = q.spd_s2 != q.spd_prev;
      if (spdif_tx) begin
         d.spd_cnt = (q.spd_cnt == 8'hFF) ? q.spd_cnt : q.spd_cnt + 8'd1;
         if (q.spd_cnt < UI_SHORT) begin
            ui = 2'd1;
         end else if (q.spd_cnt < UI_LONG) begin
            ui = 2'd2;
         end
         if (spd_edge) begin
            d.spd_cnt = 8'd1;
            if (q.pre_ui != 4'h0) begin
               if (q.pre_first) begin
                  d.pre_first = 1'b0;
                  d.pre_kind = (ui == 2'd1) ? PRE_B
                             : (ui == 2'd3) ? PRE_M : PRE_W;
               end
               d.pre_ui = q.pre_ui + {2'b00, ui};
               if (d.pre_ui >= SPD_PRE_UI) begin
                  d.pre_ui = 4'h0;
                  d.bit_idx = 5'd0;
                  d.half = 1'b0;
               end
            end else if (ui == 2'd3) begin
               d.pre_ui = 4'd3;
               d.pre_first = 1'b1;
            end else if (ui == 2'd2) begin
               spd_got = 1'b1;
            end else if (q.half) begin
               spd_got = 1'b1;
               spd_bit = 1'b1;
               d.half = 1'b0;
            end else begin
               d.half = 1'b1;
            end
         end
      end
      if (spd_got && q.bit_idx <= SPD_LAST_BIT) begin
         d.spd_word[q.bit_idx] = spd_bit;
         d.bit_idx = q.bit_idx + 5'd1;
         if (q.bit_idx == SPD_LAST_BIT) begin
            emit = 1'b1;
            emit_s = {d.spd_word[23:8], 8'h00};
            emit_r = q.pre_kind == PRE_W;
            if (q.pre_kind != PRE_W) begin
               cs_i = (q.pre_kind == PRE_B) ? 6'd0 : q.cs_idx;
               if (cs_i < SPD_CS_BITS) begin
                  d.cs[cs_i[4:0]] = d.spd_word[SPD_C_POS];
                  d.cs_idx = cs_i + 6'd1;
                  if (cs_i == SPD_CS_BITS - 6'd1) begin
                     d.cs_out = d.cs;
                     d.cs_valid = 1'b1;
                  end
               end
            end
         end
      end

      if (emit) begin
         d.aud = '{data: emit_s, right: emit_r, valid: 1'b1};
      end

      // per packet largest magnitude sets the lsbs to drop
      if (emit && serial_tx) begin
         if ((emit_s[23] ? ~emit_s[22:0] : emit_s[22:0]) > q.pk_max) begin
            d.pk_max = emit_s[23] ? ~emit_s[22:0] : emit_s[22:0];
         end
         d.pk_cnt = q.pk_cnt + 8'd1;
         if (q.pk_cnt >= PK_LAST) begin
            // count taken before the peak is cleared for the next packet
            d.drop = q.a_aux[AUX_COMPRESS]
                   ? drop_bits(d.pk_max) : 4'h0;
            d.pk_cnt = 8'd0;
            d.pk_max = 23'd0;
            d.pkt_end = 1'b1;
         end
      end

      // receiver output: load a slot word at each word sync change
      len24_out = q.a_out_fmt[5:4] == LEN_24;
      o_s = len24_out ? RX_SAMPLE : {RX_SAMPLE[23:8], 8'h00};
      if (q.a_out_fmt[FMT_RIGHT_JUST]) begin
         word = len24_out ? {8'h00, RX_SAMPLE} : {16'h0000, RX_SAMPLE[23:8]};
      end else if (q.a_out_fmt[FMT_NO_DELAY]) begin
         word = {o_s, 8'h00};
      end else begin
         word = {1'b0, o_s, 7'h00};
      end
      if (serial_rx && fall) begin
         if (ws_int != q.ws_last) begin
            d.ws_last = ws_int;
            d.osh = {word[30:0], 1'b0};
            d.dat_p.o = word[31];
            d.rx_take = 1'b1;
            d.rx_right = ws_int != q.a_out_fmt[FMT_WS_POL];
         end else begin
            d.osh = {q.osh[30:0], 1'b0};
            d.dat_p.o = q.osh[31];
         end
      end

      // pin directions: audio pins are inputs until configuration is loaded, spi pins always driven
      d.clk_p = '{o: bclk_int, oe: 1'b0};
      d.ws_p = '{o: ws_int, oe: 1'b0};
      d.dat_p.oe = 1'b0;
      d.req_p = '{o: q.a_tx_mode[TXM_REQ_POL] ? AUD_READY : !AUD_READY,
                  oe: 1'b0};
      d.spd_p = '{o: !q.a_aux[AUX_EXT_RESET], oe: 1'b0};
      d.mclk_p = '{o: q.mclk && q.a_tx_mode[1:0] != MCLK_OFF && !spdif_tx,
                   oe: 1'b0};
      if (q.cfg_done) begin
         d.clk_p.oe = serial_rx || (serial_tx && master);
         d.ws_p.oe = serial_rx || (serial_tx && master);
         d.dat_p.oe = serial_rx;
         d.req_p.oe = !q.role_rx;
         d.spd_p.oe = !spdif_tx;
         d.mclk_p.oe = 1'b1;
         if (spdif_rx) begin
            d.spd_p.o = 1'b0;
         end
      end
      d.cs_p = '{o: q.cfg_done ? LDR_CS_N : 1'b1, oe: 1'b1};
      d.sck_p = '{o: q.cfg_done ? LDR_SCK : 1'b1, oe: 1'b1};
      d.mosi_p = '{o: q.cfg_done ? LDR_MOSI : 1'b1, oe: 1'b1};
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         q <= '0;
         q.cs_p <= '{o: 1'b1, oe: 1'b1};
         q.sck_p <= '{o: 1'b1, oe: 1'b1};
         q.mosi_p <= '{o: 1'b1, oe: 1'b1};
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state flops
   assign REG_RDATA = q.rdata;
   assign CLK_P = q.clk_p;
   assign WS_P = q.ws_p;
   assign DATA_P = q.dat_p;
   assign REQ_P = q.req_p;
   assign SPDIF_IO_PIN_P = q.spd_p;
   assign MCLK_P = q.mclk_p;
   assign SPI_MASTER_CHIP_SELECT_N = q.cs_p;
   assign SPI_MASTER_SERIAL_CLOCK = q.sck_p;
   assign SPI_MASTER_DATA_OUT = q.mosi_p;
   assign AUD_OUT = q.aud;
   assign PKT_END = q.pkt_end;
   assign PKT_DROP = q.drop;
   assign CSTAT = q.cs_out;
   assign CSTAT_VALID = q.cs_valid;
   assign RX_TAKE = q.rx_take;
   assign RX_RIGHT = q.rx_right;

endmodule

`default_nettype wire

/* test/aio_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// pin direction, register and pulse checks
// ------------------------------------------------------------
module aio_asserts
   import aio_pkg::*;
(
   input wire logic        CORE_CLK,                 // clock
   input wire logic        RESET_N,                  // reset
   input wire aio_bus_t    BUS,                      // bus
   input wire logic [7:0]  REG_RDATA,                // read data
   input wire logic        CFG_DONE,                 // load done
   input wire aio_pin_t    CLK_P,                    // pin
   input wire aio_pin_t    WS_P,                     // pin
   input wire aio_pin_t    DATA_P,                   // pin
   input wire aio_pin_t    REQ_P,                    // pin
   input wire aio_pin_t    SPDIF_IO_PIN_P,           // pin
   input wire aio_pin_t    MCLK_P,                   // pin
   input wire aio_pin_t    SPI_MASTER_CHIP_SELECT_N, // pin
   input wire aio_pin_t    SPI_MASTER_SERIAL_CLOCK,  // pin
   input wire aio_pin_t    SPI_MASTER_DATA_OUT,      // pin
   input wire aio_sample_t AUD_OUT                   // sample
);
   default clocking @(posedge CORE_CLK); endclocking
   // any audio pin driving; seen_q marks a finished load
   wire  oe_any = CLK_P.oe | WS_P.oe | DATA_P.oe | REQ_P.oe |
                  SPDIF_IO_PIN_P.oe | MCLK_P.oe;
   logic seen_q;
   always_ff @(posedge CORE_CLK) begin
      seen_q <= RESET_N & (seen_q | CFG_DONE);
   end
   a_pins_reset: assert property (!RESET_N |=> !oe_any)
      else $error("audio pin driven in reset");
   a_spi_reset: assert property (!RESET_N |=>
      {SPI_MASTER_CHIP_SELECT_N, SPI_MASTER_SERIAL_CLOCK,
       SPI_MASTER_DATA_OUT} == 6'h3F) else $error("spi not high");
   a_spi_drive: assert property (RESET_N |-> &{SPI_MASTER_DATA_OUT.oe,
      SPI_MASTER_CHIP_SELECT_N.oe, SPI_MASTER_SERIAL_CLOCK.oe})
      else $error("spi pin released");
   a_dir_hold: assert property (!seen_q |-> !oe_any)
      else $error("direction before load");
   a_mclk_idle: assert property (!seen_q |-> !MCLK_P.o)
      else $error("master clock before load");
   a_rate_rsvd: assert property (disable iff (!RESET_N)
      $past(BUS.rd) && $past(BUS.addr) == OFS_INPUT_RATE_STATUS
      |-> (REG_RDATA & 8'h86) == 8'h00) else $error("reserved bit set");
   a_clk_ws_dir: assert property (disable iff (!RESET_N)
      CLK_P.oe == WS_P.oe && !(REQ_P.oe && DATA_P.oe))
      else $error("clock, sync or data direction wrong");
   a_aud_pulse: assert property (disable iff (!RESET_N)
      AUD_OUT.valid |=> !AUD_OUT.valid) else $error("valid too long");
endmodule
bind aio_top aio_asserts u_chk (.*);
`default_nettype wire

/* test/aio_src.sv */
`timescale 1ns/1ps
`default_nettype none
module aio_src (
   input  wire logic        req_n, // request, active low
   input  wire logic [31:0] frame, // left then right
   output logic             clk,   // bit clock
   output logic             ws,    // word sync
   output logic             dat    // serial data
);
   int         s = 32; // start in a right slot
   logic [5:0] j;
   // 160 ns bit clock, 32 clocks per channel, 16 data bits then zeros
   // data and sync move on falls; a paused clock holds the pending bit
   initial begin
      clk = 1'b1;
      ws  = 1'b1;
      dat = 1'b0;
      forever begin
         #80;
         if (clk) begin
            clk = 1'b0;
            j   = 6'(s + 63); // msb one bit after the sync change
            ws  = s[5];
            dat = !j[4] && frame[31 - {j[5], j[3:0]}];
            s   = (s + 1) % 64;
         end else if (!req_n) clk = 1'b1; // run on request
      end
   end
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import aio_pkg::*;
   logic CORE_CLK = 1'b0, RESET_N = 1'b0, CFG_DONE = 1'b0, go = 1'b0;
   logic ROLE_RX_I = 1'b0, AUD_READY = 1'b1, LDR_CS_N = 1'b1;
   logic LDR_SCK = 1'b0, LDR_MOSI = 1'b0, SPDIF_IO_PIN_I = 1'b0;
   logic CLK_I, WS_I, DATA_I, PKT_END, CSTAT_VALID, RX_TAKE, RX_RIGHT;
   logic [23:0] RX_SAMPLE = 24'h000000;
   logic [7:0]  REG_RDATA;
   logic [3:0]  PKT_DROP;
   logic [31:0] CSTAT, frame = 32'h00EA_0012;
   aio_bus_t    BUS = '0;
   aio_pin_t    CLK_P, WS_P, DATA_P, REQ_P, SPDIF_IO_PIN_P, MCLK_P;
   aio_pin_t    SPI_MASTER_CHIP_SELECT_N, SPI_MASTER_SERIAL_CLOCK;
   aio_pin_t    SPI_MASTER_DATA_OUT;
   aio_sample_t AUD_OUT;
   int          n_errors = 0, comparisons = 0, cyc = 0, k;
   logic        mclk_prev;
   aio_top #(.PACKET_SAMPLES(4)) u_dut (.*);
   aio_src u_src (.req_n(REQ_P.o | ~go), .frame(frame), .clk(CLK_I),
                  .ws(WS_I), .dat(DATA_I));
   // clock, and a ceiling well above the expected run
   initial forever #10 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [6:0] a, logic [7:0] d);
      @(posedge CORE_CLK) BUS <= '{a, d, 1'b1, 1'b0};
      @(posedge CORE_CLK) BUS.wr <= 1'b0;
   endtask
   task automatic rd(logic [6:0] a, logic [7:0] e);
      @(posedge CORE_CLK) BUS <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge CORE_CLK) BUS.rd <= 1'b0;
      #1 check("rdata", REG_RDATA, e);
   endtask
   // w 0 left, 1 right, 2 packet end; bounded so a hang reports
   task automatic wait_on(int w);
      int n;
      n = 0;
      do begin
         @(posedge CORE_CLK);
         #1 n++;
      end while (n < 5000 && !(w == 2 ? PKT_END === 1'b1 :
                 AUD_OUT.valid === 1'b1 && AUD_OUT.right === w[0]));
      check("wait", 24'(n >= 5000), 24'h0);
   endtask
   task automatic close_out();
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      rd(OFS_INPUT_RATE_STATUS, 8'h00);
      wr(OFS_INPUT_RATE_STATUS, 8'hD6);
      rd(OFS_INPUT_RATE_STATUS, 8'h50);
      rd(7'h7B, 8'h00);
      @(posedge CORE_CLK) CFG_DONE <= 1'b1;
      @(posedge CORE_CLK) CFG_DONE <= 1'b0;
      go <= 1'b1;
      wait_on(0);
      check("left", AUD_OUT.data, {frame[31:16], 8'h00});
      wait_on(1);
      check("right", AUD_OUT.data, {frame[15:0], 8'h00});
      wait_on(2);
      check("drop off", PKT_DROP, 4'h0);
      wr(OFS_AUX_CONTROL, 8'h01);
      wr(OFS_LINK_MODE, 8'h10);
      wait_on(2);
      wait_on(2);
      check("drop on", PKT_DROP, 4'h1);
      // auto detect starts at the register write, no apply needed; this word sync rate is in no table row
      wr(OFS_INPUT_RATE_STATUS, 8'h01);
      wr(OFS_LINK_MODE, 8'h10);
      repeat (3000) @(posedge CORE_CLK);
      rd(OFS_INPUT_RATE_STATUS, {1'b0, DET_MISS, 3'b001});
      wr(OFS_TX_MODE, 8'h04);
      wr(OFS_LINK_MODE, 8'h10);
      k = 0;
      repeat (2000) begin
         @(posedge CORE_CLK);
         #1 k += (AUD_OUT.valid === 1'b1);
      end
      check("serial muted", 24'(k), 24'h0);
      go <= 1'b0;
      wr(OFS_TX_MODE, 8'h03);
      wr(OFS_INPUT_FMT, 8'h80);
      repeat (3) @(posedge CORE_CLK);
      #1 check("slave dir", CLK_P.oe, 1'b0);
      wr(OFS_LINK_MODE, 8'h10);
      AUD_READY <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      #1 check("master dir", {CLK_P.oe, WS_P.oe, DATA_P.oe}, 3'b110);
      check("request", REQ_P, 2'b11);
      check("pin dir", {SPDIF_IO_PIN_P, MCLK_P.oe}, 3'b111);
      // 256 x 32 kSPS over 1000 cycles of 20 ns: 327.68 toggles
      mclk_prev = MCLK_P.o;
      k = 0;
      repeat (1000) begin
         @(posedge CORE_CLK);
         #1 k += (MCLK_P.o !== mclk_prev);
         mclk_prev = MCLK_P.o;
      end
      check("mclk toggles", 24'(k == 327 || k == 328), 24'h1);
      close_out();
   end
endmodule
`default_nettype wire
